// >>> err_flag_unit.sv
/*
  sticky error flags of the extended read parameter register.
  assumes one-cycle event pulses from the program/erase engine.
*/
`include "ext_read_reg_defs.svh"

module err_flag_unit (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // events and clears
  input wire ext_read_reg_pkg::op_events_t events,
  input wire logic clear_flags,
  input wire logic soft_reset,
  // flags
  output ext_read_reg_pkg::err_flags_t flags
);

  typedef struct packed {
    ext_read_reg_pkg::err_flags_t f;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic set_prot;
  logic set_prog;
  logic set_erase;

  // decode which flag each event raises
  always_comb begin
    set_prot = events.erase_protected | events.pp_protected | events.irp_locked | events.asp_lock_viol
      | events.pwd_mismatch | events.sr_write_prot | events.chip_erase_bp;
    set_prog = events.pp_fail | events.pp_protected | events.frw_fail
      | events.irp_fail | events.irp_locked
      | events.asp_fail | events.asp_lock_viol
      | events.pwd_mismatch
      | events.nv_prog_fail;
    set_erase = events.nv_erase_fail
      | events.sr_write_prot
      | events.erase_fail | events.erase_protected
      | events.chip_erase_bp;
  end

  // sticky: a set in the clearing cycle wins so no failure goes unseen
  always_comb begin
    st_nxt = st_r;
    if (clear_flags || soft_reset) begin
      st_nxt.f = '0;
    end
    if (set_prot) st_nxt.f.prot_err = 1'b1;
    if (set_prog) st_nxt.f.prog_err = 1'b1;
    if (set_erase) st_nxt.f.erase_err = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.f;

endmodule : err_flag_unit

// >>> ext_read_reg.sv
/*
  extended read parameter register: drive strength in a volatile and a
  non-volatile copy, busy mirror and three sticky error flags.
  assumes a serial front end that has already decoded the opcode and data
  byte, and a flash engine that reports the non-volatile cell update.
*/
// Behaviour
// - drive 7:5, reserved 4, errors 3:1, busy 0
// - bits 3:0 read-only, untouched by set commands
// - 85h writes non-volatile copy, 83h volatile only
// - busy bit mirrors status register bit 0
// - drive code selects strength, 111 default
// - protection error on protected or locked access
// - program commands set program fail, protected both
// - info row program fail; locked sets both
// - bad mode lock program sets both flags
// - wrong unlock password sets both flags
// - non-volatile update phase failure sets matching flag
// - protected status write sets protection and erase
// - erase commands set erase fail, protected both
// - chip erase flags block protection, not sector
// - one-time bits ignore writes back to zero
// - read-only or frozen data bits silently ignored
// - error flags stay set until clear command
// - hardware or software reset clears error flags
// - commands still execute with error flags set
`include "ext_read_reg_defs.svh"

module ext_read_reg #(
  parameter logic [7:0] READ_OPCODE = `OPC_READ_PARAMS_DEF,
  parameter logic [7:0] CLEAR_OPCODE = `OPC_CLEAR_FLAGS_DEF,
  parameter int DRIVE_WIDTH = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_reset,
  // decoded command from the serial front end
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  // device status
  input wire logic status_busy,
  input wire logic drive_freeze,
  // non-volatile copy as loaded at power up
  input wire logic nv_load,
  input wire logic [2:0] nv_load_drive,
  // non-volatile cell update handshake
  output logic nv_erase_req,
  output logic nv_prog_req,
  output logic [2:0] nv_prog_data,
  input wire logic nv_done,
  input wire logic nv_fail,
  // outcome reports from the program/erase engine
  input wire ext_read_reg_pkg::op_events_t events,
  // register view
  output logic [7:0] read_data,
  output logic read_valid,
  output ext_read_reg_pkg::drive_strength_t drive_strength,
  output logic [2:0] drive_nv_copy,
  output logic nv_busy
);

  // refuse a drive field that the register layout cannot hold
  if (DRIVE_WIDTH != 3) begin : g_bad_width
    $error("drive field must be three bits wide");
  end

  typedef struct packed {
    logic [2:0] drive_v;
    logic [2:0] drive_nv;
    logic [2:0] pend;
    ext_read_reg_pkg::nv_state_t nv_st;
    logic [7:0] rdata;
    logic rvalid;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  ext_read_reg_pkg::op_events_t ev_all;
  ext_read_reg_pkg::err_flags_t flags;
  logic clear_cmd;
  logic [7:0] reg_view;

  // only the opcode is decoded; error flags never gate acceptance
  assign clear_cmd = cmd_valid && cmd_opcode == CLEAR_OPCODE;

  // merge the engine reports with failures of the local non-volatile update
  always_comb begin
    ev_all = events;
    ev_all.nv_erase_fail = events.nv_erase_fail
      | (st_r.nv_st == ext_read_reg_pkg::ST_NV_ERASE && nv_done && nv_fail);
    ev_all.nv_prog_fail = events.nv_prog_fail
      | (st_r.nv_st == ext_read_reg_pkg::ST_NV_PROG && nv_done && nv_fail);
  end

  err_flag_unit u_flags (
    .clk_sys(clk_sys),
    .rst(rst),
    .events(ev_all),
    .clear_flags(clear_cmd),
    .soft_reset(soft_reset),
    .flags(flags)
  );

  // live register image
  always_comb begin
    reg_view = 8'h00;
    reg_view[`DRIVE_MSB:`DRIVE_LSB] = st_r.drive_v;
    reg_view[`BIT_RSVD] = `RSVD_READ;
    reg_view[`BIT_ERASE_ERR] = flags.erase_err;
    reg_view[`BIT_PROG_ERR] = flags.prog_err;
    reg_view[`BIT_PROT_ERR] = flags.prot_err;
    reg_view[`BIT_BUSY] = status_busy;
  end

  // command handling and the erase-then-program update of the nv copy
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (nv_load) begin
      st_nxt.drive_nv = nv_load_drive;
      st_nxt.drive_v = nv_load_drive;
    end
    if (cmd_valid) begin
      if (cmd_opcode == READ_OPCODE) begin
        st_nxt.rdata = reg_view;
        st_nxt.rvalid = 1'b1;
      end else if (cmd_opcode == `OPC_SET_PARAMS_V) begin
        // only bits 7:5 are taken; status bits of the data byte fall away
        // drive bits are not one-time, so a return to 0 is taken and no flag is raised
        if (!drive_freeze) st_nxt.drive_v = cmd_data[`DRIVE_MSB:`DRIVE_LSB];
      end else if (cmd_opcode == `OPC_SET_PARAMS_NV) begin
        if (!drive_freeze && st_r.nv_st == ext_read_reg_pkg::ST_IDLE) begin
          st_nxt.pend = cmd_data[`DRIVE_MSB:`DRIVE_LSB];
          st_nxt.drive_v = cmd_data[`DRIVE_MSB:`DRIVE_LSB];
          st_nxt.nv_st = ext_read_reg_pkg::ST_NV_ERASE;
        end
      end
    end
    case (st_r.nv_st)
      ext_read_reg_pkg::ST_IDLE: begin
        // keep what the command decode chose; a default here would cancel a new update
      end
      ext_read_reg_pkg::ST_NV_ERASE: begin
        if (nv_done) begin
          // a failed erase aborts; the old cell value is kept
          st_nxt.nv_st = nv_fail ? ext_read_reg_pkg::ST_IDLE : ext_read_reg_pkg::ST_NV_PROG;
        end
      end
      ext_read_reg_pkg::ST_NV_PROG: begin
        if (nv_done) begin
          if (!nv_fail) st_nxt.drive_nv = st_r.pend;
          st_nxt.nv_st = ext_read_reg_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt.nv_st = ext_read_reg_pkg::ST_IDLE;
      end
    endcase
    // software reset reloads the volatile copy from the nv copy
    if (soft_reset) st_nxt.drive_v = st_r.drive_nv;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r.drive_v <= `DRIVE_RESET;
      st_r.drive_nv <= `DRIVE_RESET;
      st_r.pend <= `DRIVE_RESET;
      st_r.nv_st <= ext_read_reg_pkg::ST_IDLE;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign read_data = st_r.rdata;
  assign read_valid = st_r.rvalid;
  assign drive_strength = ext_read_reg_pkg::drive_strength_t'(st_r.drive_v);
  assign drive_nv_copy = st_r.drive_nv;
  assign nv_erase_req = st_r.nv_st == ext_read_reg_pkg::ST_NV_ERASE;
  assign nv_prog_req = st_r.nv_st == ext_read_reg_pkg::ST_NV_PROG;
  assign nv_prog_data = st_r.pend;
  assign nv_busy = st_r.nv_st != ext_read_reg_pkg::ST_IDLE;

endmodule : ext_read_reg

// >>> ext_read_reg_chk.sv
/*
  checker of the extended read parameter register.
  assumes only the ports of ext_read_reg; bound at the foot.
*/
module ext_read_reg_chk #(
  parameter logic [7:0] READ_OPCODE = 8'h81,
  parameter logic [7:0] CLEAR_OPCODE = 8'h82
) (
  // clock, reset, commands
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  input wire logic status_busy,
  input wire logic drive_freeze,
  input wire logic nv_load,
  input wire ext_read_reg_pkg::op_events_t events,
  // register view
  input wire logic nv_erase_req,
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire ext_read_reg_pkg::drive_strength_t drive_strength,
  input wire logic nv_busy
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // decodes; reload sources excluded since their priority is open
  wire rd_c = cmd_valid && cmd_opcode == READ_OPCODE;
  wire wr_v = cmd_valid && cmd_opcode == 8'h83 && !soft_reset && !nv_load;
  wire wr_n = cmd_valid && cmd_opcode == 8'h85 && !nv_busy && !drive_freeze;
  // clear with no event around it, a quiet cycle, then a read
  sequence clr_rd;
    $past(events) == '0 && cmd_valid && cmd_opcode == CLEAR_OPCODE && events == '0
      ##1 !cmd_valid && events == '0 ##1 rd_c;
  endsequence
  // a program failure, a cycle with no clear or reset, then a read
  sequence ev_rd;
    events.pp_fail ##1 !(cmd_valid && cmd_opcode == CLEAR_OPCODE) && !soft_reset ##1 rd_c;
  endsequence
  rd_answer_a: assert property (rd_c |=> read_valid) else $error("read not answered");
  rsvd_one_a: assert property (read_valid |-> read_data[4]) else $error("reserved bit low");
  busy_mirror_a: assert property (rd_c |=> read_data[0] == $past(status_busy)) else $error("busy bit wrong");
  vol_write_a: assert property (wr_v && !drive_freeze |=> drive_strength == $past(cmd_data[7:5]))
    else $error("volatile write lost");
  nv_start_a: assert property (wr_n |=> nv_erase_req) else $error("nv update not started");
  freeze_hold_a: assert property (wr_v && drive_freeze |=> $stable(drive_strength))
    else $error("frozen drive changed");
  flag_clear_a: assert property (clr_rd |=> read_data[3:1] == 3'h0) else $error("flags not cleared");
  prog_flag_a: assert property (ev_rd |=> read_data[2]) else $error("program flag not set");
endmodule : ext_read_reg_chk

bind ext_read_reg ext_read_reg_chk #(.READ_OPCODE(READ_OPCODE), .CLEAR_OPCODE(CLEAR_OPCODE)) u_chk (.clk_sys,
  .rst, .soft_reset, .cmd_valid, .cmd_opcode, .cmd_data, .status_busy, .drive_freeze, .nv_load, .events,
  .nv_erase_req, .read_data, .read_valid, .drive_strength, .nv_busy);

// >>> ext_read_reg_defs.svh
/*
  constants of the extended read parameter register: opcodes, bit positions,
  reset values and drive strength codes. assumes inclusion by bare name.
*/
`ifndef EXT_READ_REG_DEFS_SVH
`define EXT_READ_REG_DEFS_SVH

`define OPC_SET_PARAMS_NV 8'h85
`define OPC_SET_PARAMS_V 8'h83
`define OPC_READ_PARAMS_DEF 8'h81
`define OPC_CLEAR_FLAGS_DEF 8'h82

`define BIT_BUSY 0
`define BIT_PROT_ERR 1
`define BIT_PROG_ERR 2
`define BIT_ERASE_ERR 3
`define BIT_RSVD 4
`define DRIVE_LSB 5
`define DRIVE_MSB 7

`define DRIVE_RESET 3'h7
`define RSVD_READ 1'h1

`define DRIVE_12P5 3'h1
`define DRIVE_25 3'h2
`define DRIVE_37P5 3'h3
`define DRIVE_75 3'h5
`define DRIVE_100 3'h6
`define DRIVE_50 3'h7

`endif

// >>> ext_read_reg_pkg.sv
/*
  types shared by the extended read parameter register and its flag unit.
  assumes ext_read_reg_defs.svh for the constants.
*/
package ext_read_reg_pkg;

  // operation outcome reports from the program/erase engine
  typedef struct packed {
    logic pp_fail;          // page, protection-bit or password program failed
    logic pp_protected;     // program hit protected or erase-suspended area
    logic frw_fail;         // function register write failed
    logic irp_fail;         // info row program failed
    logic irp_locked;       // info row program into locked region
    logic asp_fail;         // protection register program failed
    logic asp_lock_viol;    // mode lock bits changed after choice, or 00b
    logic pwd_mismatch;     // unlock password did not match
    logic nv_erase_fail;    // non-volatile register update, erase phase
    logic nv_prog_fail;     // non-volatile register update, program phase
    logic sr_write_prot;    // status write while write-protected
    logic erase_fail;       // sector/block/chip/info row/ppb erase failed
    logic erase_protected;  // erase of protected area or locked info row
    logic chip_erase_bp;    // chip erase with blocks under block protection bits
  } op_events_t;

  typedef struct packed {
    logic erase_err;
    logic prog_err;
    logic prot_err;
  } err_flags_t;

  typedef enum logic [2:0] {
    DRV_RSVD0, DRV_12P5, DRV_25, DRV_37P5, DRV_RSVD4, DRV_75, DRV_100, DRV_50
  } drive_strength_t;

  typedef enum {
    ST_IDLE, ST_NV_ERASE, ST_NV_PROG
  } nv_state_t;

endpackage : ext_read_reg_pkg

// >>> extended_read_status_register_bench.sv
/*
  bench of the extended read parameter register with the flash cell model.
  assumes the checker is bound from its own file.
*/
module extended_read_status_register_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, soft_reset, cmd_valid, status_busy, drive_freeze;
  logic nv_done, nv_fail, erq, prq, read_valid, nv_busy, fe, fp;
  logic [7:0] cmd_opcode, cmd_data, read_data;
  logic [2:0] pd, nvc;
  ext_read_reg_pkg::op_events_t events;
  ext_read_reg_pkg::drive_strength_t ds;
  int err_total, n_tests, i, k;
  // data byte, busy level, expected image
  typedef struct packed {logic [7:0] d; logic b; logic [7:0] x;} row_t;
  row_t rows [6] = '{'{8'h20, 1'b1, 8'h31}, '{8'h5F, 1'b0, 8'h50}, '{8'h7F, 1'b1, 8'h71},
    '{8'hA0, 1'b0, 8'hB0}, '{8'hDF, 1'b1, 8'hD1}, '{8'hE0, 1'b0, 8'hF0}};
  // erase, program, protection flags per event bit, msb is bit 13
  localparam logic [41:0] EMAP = {3'h2, 3'h3, 3'h2, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4, 3'h2, 3'h5, 3'h4, 3'h5,
    3'h5};
  ext_read_reg dut (.clk_sys, .rst, .soft_reset, .cmd_valid, .cmd_opcode, .cmd_data, .status_busy, .drive_freeze,
    .nv_load(1'b0), .nv_load_drive(3'h0), .nv_erase_req(erq), .nv_prog_req(prq), .nv_prog_data(pd), .nv_done,
    .nv_fail, .events, .read_data, .read_valid, .drive_strength(ds), .drive_nv_copy(nvc), .nv_busy);
  nv_cell_model u_nv (.clk_sys, .rst, .erase_req(erq), .prog_req(prq), .fail_erase(fe), .fail_prog(fp),
    .done(nv_done), .fail(nv_fail));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [8:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, d);
    @(posedge clk_sys);
    #2 cmd_valid = 1'b1;
    cmd_opcode = op;
    cmd_data = d;
    @(posedge clk_sys);
    #2 cmd_valid = 1'b0;
  endtask : cmd
  // the answer is registered at the taking edge, so it is seen right after
  task automatic rd(input logic [7:0] x);
    cmd(8'h81, 8'h00);
    chk({read_valid, read_data}, {1'b1, x});
  endtask : rd
  // time steps keep the poll off the clock edge
  task automatic nv_wr(input logic [7:0] d, input logic [2:0] x);
    cmd(8'h85, d);
    for (k = 0; k < 50 && nv_busy !== 1'b0; k++)
      #25;
    chk({6'h0, nvc}, {6'h0, x});
    chk({6'h0, pd}, {6'h0, d[7:5]});
  endtask : nv_wr
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
  initial begin
    {rst, soft_reset, cmd_valid, status_busy, drive_freeze, fe, fp} = 7'h40;
    {cmd_opcode, cmd_data} = 16'h0;
    events = '0;
    repeat (3) @(posedge clk_sys);
    #2 rst = 1'b0;
    rd(8'hF0);
    $display("reset test done");
    for (i = 0; i < 6; i++) begin
      status_busy = rows[i].b;
      cmd(8'h83, rows[i].d);
      rd(rows[i].x);
      chk({6'h0, ds}, {6'h0, rows[i].x[7:5]});
    end
    $display("table test done");
    drive_freeze = 1'b1;
    cmd(8'h83, 8'h20);
    cmd(8'h85, 8'h20);
    chk({8'h0, nv_busy}, 9'h0);
    rd(8'hF0);
    drive_freeze = 1'b0;
    $display("freeze test done");
    for (i = 0; i < 14; i++) begin
      @(posedge clk_sys);
      #2 events = ext_read_reg_pkg::op_events_t'(14'h1 << i);
      @(posedge clk_sys);
      #2 events = '0;
      rd({4'hF, EMAP[3*i+:3], 1'b0});
      cmd(8'h83, 8'h20);
      rd({4'h3, EMAP[3*i+:3], 1'b0});
      cmd(8'h82, 8'h00);
      rd(8'h30);
      cmd(8'h83, 8'hE0);
    end
    @(posedge clk_sys);
    #2 events.erase_fail = 1'b1;
    @(posedge clk_sys);
    #2 events = '0;
    soft_reset = 1'b1;
    @(posedge clk_sys);
    #2 soft_reset = 1'b0;
    rd(8'hF0);
    $display("flag test done");
    nv_wr(8'hA0, 3'h5);
    rd(8'hB0);
    fe = 1'b1;
    nv_wr(8'hC0, 3'h5);
    rd(8'hD8);
    fe = 1'b0;
    fp = 1'b1;
    cmd(8'h82, 8'h00);
    nv_wr(8'h20, 3'h5);
    rd(8'h34);
    fp = 1'b0;
    $display("nv update test done");
    // soft reset reloads the volatile drive from the nv copy and clears the flags
    soft_reset = 1'b1;
    @(posedge clk_sys);
    #2 soft_reset = 1'b0;
    rd(8'hB0);
    // mid-run hardware reset back to the reset image
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2 rst = 1'b0;
    rd(8'hF0);
    $display("mid-run reset test done");
    end_sim;
  end
endmodule : extended_read_status_register_bench

// >>> nv_cell_model.sv
/*
  model of the flash engine that erases and programs the non-volatile copy.
  assumes level requests held until done.
*/
module nv_cell_model #(
  parameter int DLY = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // phase requests and failure controls
  input wire logic erase_req,
  input wire logic prog_req,
  input wire logic fail_erase,
  input wire logic fail_prog,
  // answer
  output logic done,
  output logic fail
);
  int cnt;
  // fail toggles outside done so a design that samples it early is caught
  always_ff @(posedge clk_sys) begin
    done <= 1'b0;
    fail <= rst ? 1'b0 : ~fail;
    if (rst || !(erase_req || prog_req)) begin
      cnt <= 0;
    end else if (!done) begin
      cnt <= cnt + 1;
      if (cnt == DLY) begin
        done <= 1'b1;
        fail <= erase_req ? fail_erase : fail_prog;
        cnt <= 0;
      end
    end
  end
endmodule : nv_cell_model
